// *** rtl/usart_pkg.sv ***
// Constants and types shared by the serial port design
package usart_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] A_FLAG = 5'h00;
	localparam logic [ADDR_W-1:0] A_DATA = 5'h04;
	localparam logic [ADDR_W-1:0] A_BAUD = 5'h08;
	localparam logic [ADDR_W-1:0] A_CR1 = 5'h0c;
	localparam logic [ADDR_W-1:0] A_CR2 = 5'h10;
	localparam logic [ADDR_W-1:0] A_CR3 = 5'h14;
	localparam logic [2:0] IX_FLAG = 3'h0;
	localparam logic [2:0] IX_DATA = 3'h1;
	localparam logic [2:0] IX_BAUD = 3'h2;
	localparam logic [2:0] IX_CR1 = 3'h3;
	localparam logic [2:0] IX_CR2 = 3'h4;
	localparam logic [2:0] IX_CR3 = 3'h5;
	localparam logic [2:0] IX_NONE = 3'h7;
	// Flag register bit positions
	localparam int F_PE = 0;
	localparam int F_FE = 1;
	localparam int F_ORE = 3;
	localparam int F_IDLE = 4;
	localparam int F_RX_WORD_AVAIL = 5;
	localparam int F_TC = 6;
	localparam int F_TXE = 7;
	localparam logic [7:0] FLAG_RST = 8'hc0;
	localparam logic [7:0] FLAG_W1C = 8'h5b;
	localparam int OVS_SHIFT = 4;
	localparam int SYNC_SHIFT = 2;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	typedef struct packed {
		logic quiet_irq_on;
		logic rx_avail_irq_on;
		logic tx_done_irq_on;
		logic tx_slot_irq_on;
		logic sync_sel;
		logic msb_first;
		logic parity_odd;
		logic parity_on;
		logic word_len_sel;
		logic rx_allow;
		logic tx_allow;
		logic unit_on;
	} cr1_t;
	typedef struct packed {
		logic stop2;
		logic clk_edge_sel;
		logic clk_idle_level;
		logic clock_pin_on;
	} cr2_t;
	typedef struct packed {
		logic cts_check;
		logic one_wire_sel;
		logic ext_clk_sel;
	} cr3_t;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_st_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_st_t;
endpackage

// *** rtl/usart_txrx_sync_mode.sv ***
// Serial port with synchronous mode: AXI4-Lite registers, transmitter and receiver
// ----------------------------------------
// Summary of operation
// - With clear-to-send checking, start only while low
// - Word written to empty buffer starts transmission
// - Buffer-to-shifter move sets slot-free, may interrupt
// - Last bit gone, buffer empty: set done
// - Start bit begins reception; frame sets word-available
// - Frame: start, data, optional parity, stop
// - Async word length eight or nine bits
// - Break frame sets framing fault
// - Idle frame sets line-quiet flag, may interrupt
// - Reading data buffer clears word-available
// - Overrun discards word, sets overflow flag
// - Parity/framing fault stores word, no available
// - Any fault flag blocks further reception
// - Synchronous select activates clock pin only with clock pin enable set
// - Master drives baud clock; slave takes pin
// - Clock pin enable and external clock select
// - Exactly eight clock pulses, data bits only
// - Both directions off: clock rests at idle
// - After last bit, data and clock hold
// - Sync receive samples on selected edge only
// - Sync bit rate is clock over four divider
// ----------------------------------------
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module usart_txrx_sync_mode #(
	parameter int DIV_W = 16
) (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic CE,
	input wire logic [usart_pkg::ADDR_W-1:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [usart_pkg::ADDR_W-1:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic TXD,
	input wire logic RXD,
	input wire logic CTS_N,
	input wire logic SCLK_IN,
	output logic SCLK_OUT,
	output logic SCLK_OE_N,
	output logic IRQ
);
	localparam int CW = DIV_W + 4;

	function automatic logic [2:0] dec(input logic [usart_pkg::ADDR_W-1:0] a);
		unique case ({a[usart_pkg::ADDR_W-1:2], 2'b00})
			usart_pkg::A_FLAG: dec = usart_pkg::IX_FLAG;
			usart_pkg::A_DATA: dec = usart_pkg::IX_DATA;
			usart_pkg::A_BAUD: dec = usart_pkg::IX_BAUD;
			usart_pkg::A_CR1: dec = usart_pkg::IX_CR1;
			usart_pkg::A_CR2: dec = usart_pkg::IX_CR2;
			usart_pkg::A_CR3: dec = usart_pkg::IX_CR3;
			default: dec = usart_pkg::IX_NONE;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			o[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
		end
		merge = o;
	endfunction

	usart_pkg::cr1_t c1;
	usart_pkg::cr2_t c2;
	usart_pkg::cr3_t c3;
	logic [DIV_W-1:0] div;
	logic [8:0] dbuf, rdr;
	logic [7:0] flg;
	logic rx1, rx_s, cts1, cts_s, sc1, sc2, sc3;
	logic aw_h, w_h;
	logic [usart_pkg::ADDR_W-1:0] aw_a;
	logic [31:0] w_d, m;
	logic [3:0] w_s;
	logic wr_fire, rd_fire, rd_dr;
	logic [2:0] wsel;
	logic [31:0] rdval;
	logic sync, master, slave_sync, nb9, blk;
	logic [DIV_W-1:0] d;
	logic [CW-1:0] blen, hlen;
	logic [3:0] nlast;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			{rx1, rx_s, cts1, cts_s} <= 4'hf;
			{sc1, sc2, sc3} <= 3'h0;
		end else if (CE) begin
			rx1 <= RXD;
			rx_s <= rx1;
			cts1 <= CTS_N;
			cts_s <= cts1;
			sc1 <= SCLK_IN;
			sc2 <= sc1;
			sc3 <= sc2;
		end
	end

	// ----------------------------------------
	// Mode and timing
	// ----------------------------------------
	always_comb begin
		sync = c1.sync_sel;
		master = !c3.ext_clk_sel;
		slave_sync = sync && !master;
		nb9 = c1.word_len_sel && !sync;
		nlast = nb9 ? 4'h8 : 4'h7;
		d = (div == '0) ? DIV_W'(1) : div;
		blen = sync ? (CW'(d) << usart_pkg::SYNC_SHIFT) : (CW'(d) << usart_pkg::OVS_SHIFT);
		hlen = blen >> 1;
		blk = flg[usart_pkg::F_PE] | flg[usart_pkg::F_FE] | flg[usart_pkg::F_ORE];
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	assign AWREADY = !aw_h;
	assign WREADY = !w_h;
	assign ARREADY = !RVALID;
	assign wr_fire = CE && aw_h && w_h && !BVALID;
	assign rd_fire = CE && ARVALID && !RVALID;
	assign wsel = dec(aw_a);
	assign rd_dr = rd_fire && dec(ARADDR) == usart_pkg::IX_DATA;

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			aw_h <= 1'b0;
			w_h <= 1'b0;
			aw_a <= '0;
			w_d <= '0;
			w_s <= '0;
			BVALID <= 1'b0;
			BRESP <= usart_pkg::RESP_OK;
		end else if (CE) begin
			if (AWVALID && !aw_h) begin
				aw_h <= 1'b1;
				aw_a <= AWADDR;
			end
			if (WVALID && !w_h) begin
				w_h <= 1'b1;
				w_d <= WDATA;
				w_s <= WSTRB;
			end
			if (wr_fire) begin
				aw_h <= 1'b0;
				w_h <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= (wsel == usart_pkg::IX_NONE) ? usart_pkg::RESP_ERR : usart_pkg::RESP_OK;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (dec(ARADDR))
			usart_pkg::IX_FLAG: rdval = 32'(flg);
			usart_pkg::IX_DATA: rdval = 32'(rdr);
			usart_pkg::IX_BAUD: rdval = 32'(div);
			usart_pkg::IX_CR1: rdval = 32'(c1);
			usart_pkg::IX_CR2: rdval = 32'(c2);
			usart_pkg::IX_CR3: rdval = 32'(c3);
			default: rdval = '0;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			RVALID <= 1'b0;
			RDATA <= '0;
			RRESP <= usart_pkg::RESP_OK;
		end else if (CE) begin
			if (rd_fire) begin
				RVALID <= 1'b1;
				RDATA <= rdval;
				RRESP <= (dec(ARADDR) == usart_pkg::IX_NONE) ? usart_pkg::RESP_ERR : usart_pkg::RESP_OK;
			end else if (RREADY) begin
				RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	always_comb begin
		unique case (wsel)
			usart_pkg::IX_BAUD: m = merge(32'(div), w_d, w_s);
			usart_pkg::IX_CR1: m = merge(32'(c1), w_d, w_s);
			usart_pkg::IX_CR2: m = merge(32'(c2), w_d, w_s);
			default: m = merge(32'(c3), w_d, w_s);
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			c1 <= '0;
			c2 <= '0;
			c3 <= '0;
			div <= '0;
		end else if (wr_fire) begin
			if (wsel == usart_pkg::IX_BAUD)
				div <= m[DIV_W-1:0];
			if (wsel == usart_pkg::IX_CR1)
				c1 <= usart_pkg::cr1_t'(m[$bits(usart_pkg::cr1_t)-1:0]);
			if (wsel == usart_pkg::IX_CR2)
				c2 <= usart_pkg::cr2_t'(m[$bits(usart_pkg::cr2_t)-1:0]);
			if (wsel == usart_pkg::IX_CR3)
				c3 <= usart_pkg::cr3_t'(m[$bits(usart_pkg::cr3_t)-1:0]);
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	usart_pkg::tx_st_t tst;
	logic [CW-1:0] tcnt;
	logic [3:0] tidx, tsc;
	logic [8:0] tsh, tw;
	logic tfirst, ttick, tx_go, tx_load, tx_end, next_txd, next_sclk;
	logic m_smp, lead, trail, s_smp, s_shift, smp, sh_ev;

	always_comb begin
		ttick = tcnt == '0;
		tx_go = c1.unit_on && c1.tx_allow && !flg[usart_pkg::F_TXE] && !(c3.cts_check && cts_s);
		tx_load = CE && tst == usart_pkg::TX_IDLE && tx_go;
		tx_end = CE && tst == usart_pkg::TX_STOP && ttick && !(c2.stop2 && tidx == 4'h0);
		m_smp = tst == usart_pkg::TX_DATA && tcnt == hlen - 1'b1;
		lead = sc2 != sc3 && sc3 == c2.clk_idle_level;
		trail = sc2 != sc3 && sc2 == c2.clk_idle_level;
		s_smp = c2.clk_edge_sel ? trail : lead;
		s_shift = c2.clk_edge_sel ? lead : trail;
		smp = sync && c2.clock_pin_on && (master ? m_smp : s_smp);
		sh_ev = s_shift && c2.clock_pin_on && !(c2.clk_edge_sel && tfirst);
		tw = nb9 ? tsh : {1'b0, tsh[7:0]};
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			tst <= usart_pkg::TX_IDLE;
			tcnt <= '0;
			tidx <= '0;
			tsc <= '0;
			tsh <= '0;
			tfirst <= 1'b0;
		end else if (CE) begin
			if (!c1.tx_allow) begin
				tst <= usart_pkg::TX_IDLE;
			end else begin
				unique case (tst)
					usart_pkg::TX_IDLE: if (tx_go) begin
						tsh <= dbuf;
						tidx <= '0;
						tsc <= '0;
						tfirst <= 1'b1;
						tcnt <= blen - 1'b1;
						tst <= slave_sync ? usart_pkg::TX_DATA : usart_pkg::TX_START;
					end
					usart_pkg::TX_START: if (ttick) begin
						tcnt <= blen - 1'b1;
						tst <= usart_pkg::TX_DATA;
					end else begin
						tcnt <= tcnt - 1'b1;
					end
					usart_pkg::TX_DATA: if (slave_sync) begin
						if (sh_ev)
							tidx <= tidx + 4'h1;
						if (s_shift)
							tfirst <= 1'b0;
						if (smp)
							tsc <= tsc + 4'h1;
						if (smp && tsc == usart_pkg::SYNC_BITS - 4'h1) begin
							tidx <= '0;
							tcnt <= blen - 1'b1;
							tst <= usart_pkg::TX_STOP;
						end
					end else if (ttick) begin
						tcnt <= blen - 1'b1;
						if (tidx == nlast) begin
							tidx <= '0;
							tst <= c1.parity_on ? usart_pkg::TX_PAR : usart_pkg::TX_STOP;
						end else begin
							tidx <= tidx + 4'h1;
						end
					end else begin
						tcnt <= tcnt - 1'b1;
					end
					usart_pkg::TX_PAR: if (ttick) begin
						tcnt <= blen - 1'b1;
						tst <= usart_pkg::TX_STOP;
					end else begin
						tcnt <= tcnt - 1'b1;
					end
					usart_pkg::TX_STOP: if (ttick) begin
						tcnt <= blen - 1'b1;
						if (c2.stop2 && tidx == 4'h0)
							tidx <= 4'h1;
						else
							tst <= usart_pkg::TX_IDLE;
					end else begin
						tcnt <= tcnt - 1'b1;
					end
					default: tst <= usart_pkg::TX_IDLE;
				endcase
			end
		end
	end

	// Line and clock levels; in sync mode the line holds outside data bits
	always_comb begin
		unique case (tst)
			usart_pkg::TX_START: next_txd = sync ? TXD : 1'b0;
			usart_pkg::TX_DATA: next_txd = c1.msb_first ? tw[nlast - tidx] : tw[tidx];
			usart_pkg::TX_PAR: next_txd = sync ? TXD : (^tw ^ c1.parity_odd);
			default: next_txd = sync ? TXD : 1'b1;
		endcase
		next_sclk = c2.clk_idle_level ^ (sync && master && (c1.tx_allow || c1.rx_allow)
			&& tst == usart_pkg::TX_DATA && (c2.clk_edge_sel ? tcnt >= hlen : tcnt < hlen));
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			TXD <= 1'b1;
			SCLK_OUT <= 1'b0;
		end else if (CE) begin
			TXD <= next_txd;
			SCLK_OUT <= next_sclk;
		end
	end

	assign SCLK_OE_N = !(sync && c2.clock_pin_on && master);

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	usart_pkg::rx_st_t rst;
	logic [CW-1:0] rcnt;
	logic [3:0] ridx;
	logic [8:0] rsh, rword, shin;
	logic rpbit, rdone, rfe, rpe, rtick, r_allow;

	always_comb begin
		rtick = rcnt == '0;
		r_allow = c1.unit_on && c1.rx_allow && !blk;
		shin = c1.msb_first ? {rsh[7:0], rx_s} : {rx_s, rsh[8:1]};
		rword = nb9 ? rsh : (c1.msb_first ? {1'b0, rsh[7:0]} : {1'b0, rsh[8:1]});
		rpe = c1.parity_on && !sync && (^rword ^ rpbit ^ c1.parity_odd);
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			rst <= usart_pkg::RX_IDLE;
			rcnt <= '0;
			ridx <= '0;
			rsh <= '0;
			rpbit <= 1'b0;
			rdone <= 1'b0;
			rfe <= 1'b0;
		end else if (CE) begin
			rdone <= 1'b0;
			if (!r_allow) begin
				rst <= usart_pkg::RX_IDLE;
			end else begin
				unique case (rst)
					usart_pkg::RX_IDLE: begin
						ridx <= '0;
						rcnt <= hlen - 1'b1;
						if (sync)
							rst <= usart_pkg::RX_DATA;
						else if (!rx_s)
							rst <= usart_pkg::RX_START;
					end
					usart_pkg::RX_START: if (rtick) begin
						rcnt <= blen - 1'b1;
						rst <= rx_s ? usart_pkg::RX_IDLE : usart_pkg::RX_DATA;
					end else begin
						rcnt <= rcnt - 1'b1;
					end
					usart_pkg::RX_DATA: if (sync ? smp : rtick) begin
						rsh <= shin;
						rcnt <= blen - 1'b1;
						ridx <= ridx + 4'h1;
						if (ridx == nlast) begin
							ridx <= '0;
							rfe <= 1'b0;
							rdone <= sync;
							rst <= sync ? usart_pkg::RX_IDLE
								: (c1.parity_on ? usart_pkg::RX_PAR : usart_pkg::RX_STOP);
						end
					end else if (!sync) begin
						rcnt <= rcnt - 1'b1;
					end
					usart_pkg::RX_PAR: if (rtick) begin
						rpbit <= rx_s;
						rcnt <= blen - 1'b1;
						rst <= usart_pkg::RX_STOP;
					end else begin
						rcnt <= rcnt - 1'b1;
					end
					usart_pkg::RX_STOP: if (rtick) begin
						rdone <= 1'b1;
						rfe <= !rx_s;
						rst <= usart_pkg::RX_IDLE;
					end else begin
						rcnt <= rcnt - 1'b1;
					end
					default: rst <= usart_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Idle line detection
	// ----------------------------------------
	logic qarm, idle_hit;
	logic [CW-1:0] qcnt;
	logic [3:0] qb, fb;

	always_comb begin
		fb = nlast + 4'h3 + {3'h0, c1.parity_on} + {3'h0, c2.stop2};
		idle_hit = CE && qarm && !sync && rx_s && rst == usart_pkg::RX_IDLE && r_allow
			&& qcnt == '0 && qb == fb - 4'h1;
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			qarm <= 1'b0;
			qcnt <= '0;
			qb <= '0;
		end else if (CE) begin
			if (sync || !rx_s || rst != usart_pkg::RX_IDLE || !r_allow || !qarm) begin
				qcnt <= blen - 1'b1;
				qb <= '0;
			end else if (qcnt == '0) begin
				qcnt <= blen - 1'b1;
				qb <= qb + 4'h1;
				if (idle_hit)
					qarm <= 1'b0;
			end else begin
				qcnt <= qcnt - 1'b1;
			end
			if (rdone)
				qarm <= 1'b1;
		end
	end

	// ----------------------------------------
	// Flags, data buffers and interrupt
	// ----------------------------------------
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			flg <= usart_pkg::FLAG_RST;
			dbuf <= '0;
			rdr <= '0;
		end else if (CE) begin
			if (wr_fire && wsel == usart_pkg::IX_FLAG)
				flg <= flg & ~(w_d[7:0] & usart_pkg::FLAG_W1C & {8{w_s[0]}});
			if (wr_fire && wsel == usart_pkg::IX_DATA) begin
				dbuf <= w_d[8:0];
				flg[usart_pkg::F_TXE] <= 1'b0;
				flg[usart_pkg::F_TC] <= 1'b0;
			end
			if (rd_dr)
				flg[usart_pkg::F_RX_WORD_AVAIL] <= 1'b0;
			if (tx_load)
				flg[usart_pkg::F_TXE] <= 1'b1;
			if (tx_end && flg[usart_pkg::F_TXE])
				flg[usart_pkg::F_TC] <= 1'b1;
			if (idle_hit)
				flg[usart_pkg::F_IDLE] <= 1'b1;
			if (rdone && !blk) begin
				if (flg[usart_pkg::F_RX_WORD_AVAIL]) begin
					flg[usart_pkg::F_ORE] <= 1'b1;
				end else begin
					rdr <= rword;
					flg[usart_pkg::F_PE] <= flg[usart_pkg::F_PE] | rpe;
					flg[usart_pkg::F_FE] <= flg[usart_pkg::F_FE] | rfe;
					flg[usart_pkg::F_RX_WORD_AVAIL] <= !rpe && !rfe;
				end
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET)
			IRQ <= 1'b0;
		else if (CE)
			IRQ <= (flg[usart_pkg::F_TXE] && c1.tx_slot_irq_on) || (flg[usart_pkg::F_TC] && c1.tx_done_irq_on)
				|| (flg[usart_pkg::F_RX_WORD_AVAIL] && c1.rx_avail_irq_on) || (flg[usart_pkg::F_IDLE] && c1.quiet_irq_on);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [3:0] pc;
	always_ff @(posedge MCLK) begin
		if (RESET || tst == usart_pkg::TX_START || tst == usart_pkg::TX_IDLE)
			pc <= '0;
		else if (CE && SCLK_OUT == c2.clk_idle_level && next_sclk != c2.clk_idle_level)
			pc <= pc + 4'h1;
	end

	a_cts_hold: assert property (@(posedge MCLK) disable iff (RESET)
		CE && tst == usart_pkg::TX_IDLE && c3.cts_check && cts_s |=> tst == usart_pkg::TX_IDLE)
		else $error("transmit started while clear-to-send high");
	a_slot_on_load: assert property (@(posedge MCLK) disable iff (RESET)
		CE && tst == usart_pkg::TX_IDLE && tx_go |=> flg[usart_pkg::F_TXE] && tst != usart_pkg::TX_IDLE)
		else $error("slot-free not set on load");
	a_done_set: assert property (@(posedge MCLK) disable iff (RESET)
		$rose(flg[usart_pkg::F_TC]) |-> $past(tst) == usart_pkg::TX_STOP && $past(flg[usart_pkg::F_TXE]))
		else $error("done set at wrong time");
	a_read_clears: assert property (@(posedge MCLK) disable iff (RESET)
		rd_dr && !rdone |=> !flg[usart_pkg::F_RX_WORD_AVAIL])
		else $error("data read left word-available set");
	a_overrun_keep: assert property (@(posedge MCLK) disable iff (RESET)
		CE && rdone && !blk && flg[usart_pkg::F_RX_WORD_AVAIL] |=> flg[usart_pkg::F_ORE] && $stable(rdr))
		else $error("overrun did not discard word");
	a_fault_noavail: assert property (@(posedge MCLK) disable iff (RESET)
		CE && rdone && !blk && !flg[usart_pkg::F_RX_WORD_AVAIL] && (rpe || rfe) && !rd_dr
		|=> !flg[usart_pkg::F_RX_WORD_AVAIL] && rdr == $past(rword))
		else $error("faulty word handled wrongly");
	a_fault_block: assert property (@(posedge MCLK) disable iff (RESET)
		CE && blk |=> rst == usart_pkg::RX_IDLE)
		else $error("reception while fault flag set");
	a_clk_rest: assert property (@(posedge MCLK) disable iff (RESET)
		CE && !c1.tx_allow && !c1.rx_allow |=> SCLK_OUT == $past(c2.clk_idle_level))
		else $error("clock not at idle level");
	a_eight_pulses: assert property (@(posedge MCLK) disable iff (RESET)
		(CE && sync && master && tst == usart_pkg::TX_DATA) ##1 (tst == usart_pkg::TX_STOP) |-> pc == 4'h8)
		else $error("frame clock pulse count not eight");
endmodule
`default_nettype wire

// *** verif/usart_peer.sv ***
// Remote serial port model: drives the receive line, captures transmit frames
`timescale 1ns/1ps
`default_nettype none
module usart_peer #(
	parameter int BIT_LEN = 16
) (
	input wire logic MCLK,
	input wire logic TXD,
	output logic RXD
);
	// Line idles high between frames
	initial RXD = 1'b1;

	// ----------------------------------------
	// Frame sender, stop level chosen for breaks
	// ----------------------------------------
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		@(posedge MCLK);
		RXD <= 1'b0;
		repeat (BIT_LEN) @(posedge MCLK);
		for (int i = 0; i < nb; i++) begin
			RXD <= d[i];
			repeat (BIT_LEN) @(posedge MCLK);
		end
		RXD <= stop;
		repeat (BIT_LEN) @(posedge MCLK);
		RXD <= 1'b1;
	endtask

	// ----------------------------------------
	// Frame capture at bit centres, low bit first
	// ----------------------------------------
	task automatic grab(output logic [7:0] d);
		while (TXD !== 1'b1) @(posedge MCLK);
		while (TXD === 1'b1) @(posedge MCLK);
		repeat (BIT_LEN / 2) @(posedge MCLK);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_LEN) @(posedge MCLK);
			d[i] = TXD;
		end
	endtask
endmodule
`default_nettype wire

// *** verif/tb_usart_txrx_sync_mode.sv ***
// Self-checking bench for the serial port with synchronous mode
`timescale 1ns/1ps
`default_nettype none
module tb_usart_txrx_sync_mode;
	logic MCLK = 1'b0, RESET = 1'b1, CE = 1'b1, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b1;
	logic ARVALID = 1'b0, RREADY = 1'b1, CTS_N = 1'b1, SCLK_IN = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TXD, RXD, SCLK_OUT, SCLK_OE_N, IRQ, p;
	logic [4:0] AWADDR = 5'h00, ARADDR = 5'h00;
	logic [31:0] WDATA = 32'h0, RDATA, rdat, sb;
	logic [3:0] WSTRB = 4'hf;
	logic [1:0] BRESP, RRESP, rresp;
	logic [7:0] b0, b1;
	int n_mismatch = 0, n_tests = 0, n, l, per;

	usart_txrx_sync_mode i_usart_txrx_sync_mode (.MCLK(MCLK), .RESET(RESET), .CE(CE), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .TXD(TXD), .RXD(RXD), .CTS_N(CTS_N),
		.SCLK_IN(SCLK_IN), .SCLK_OUT(SCLK_OUT), .SCLK_OE_N(SCLK_OE_N), .IRQ(IRQ));
	usart_peer i_usart_peer (.MCLK(MCLK), .TXD(TXD), .RXD(RXD));

	initial begin
		forever #12.5 MCLK = ~MCLK;
	end

	// ----------------------------------------
	// Bus access and comparison
	// ----------------------------------------
	// Ready and valid are looked at before the edge that takes them
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic a_ok, w_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		do begin
			@(negedge MCLK);
			if (!a_ok && AWREADY === 1'b1) a_ok = 1'b1;
			if (!w_ok && WREADY === 1'b1) w_ok = 1'b1;
			@(posedge MCLK);
			if (a_ok) AWVALID <= 1'b0;
			if (w_ok) WVALID <= 1'b0;
		end while (!(a_ok && w_ok));
		do @(negedge MCLK); while (BVALID !== 1'b1);
		@(posedge MCLK);
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		do @(negedge MCLK); while (ARREADY !== 1'b1);
		@(posedge MCLK);
		ARVALID <= 1'b0;
		do @(negedge MCLK); while (RVALID !== 1'b1);
		rdat = RDATA;
		rresp = RRESP;
		@(posedge MCLK);
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
		n_tests++;
		if (v !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", s, e, v);
		end
	endtask

	task automatic rc(input string s, input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(s, e, rdat & m);
	endtask

	task automatic results();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge MCLK);
		RESET <= 1'b0;
		rc("flag reset", usart_pkg::A_FLAG, 32'hff, 32'hc0);
		rd(5'h1c);
		chk("unmapped resp", {30'h0, usart_pkg::RESP_ERR}, {30'h0, rresp});
		chk("unmapped data", 32'h0, rdat);
		wr(usart_pkg::A_BAUD, 32'h1);
		wr(usart_pkg::A_CR1, 32'h203);
		fork
			begin
				i_usart_peer.grab(b0);
				i_usart_peer.grab(b1);
			end
			begin
				wr(usart_pkg::A_DATA, 32'ha5);
				wr(usart_pkg::A_DATA, 32'h3c);
			end
		join
		chk("tx word 0", 32'ha5, {24'h0, b0});
		chk("tx word 1", 32'h3c, {24'h0, b1});
		repeat (48) @(posedge MCLK);
		rc("tx done flags", usart_pkg::A_FLAG, 32'hc0, 32'hc0);
		chk("done irq", 32'h1, {31'h0, IRQ});
		wr(usart_pkg::A_FLAG, 32'h40);
		repeat (2) @(posedge MCLK);
		chk("done irq clear", 32'h0, {31'h0, IRQ});
		// Pending word held back while the far end refuses
		wr(usart_pkg::A_CR3, 32'h4);
		wr(usart_pkg::A_DATA, 32'h77);
		p = 1'b1;
		repeat (100) begin
			@(posedge MCLK);
			p = p & TXD;
		end
		chk("cts held line", 32'h1, {31'h0, p});
		rc("cts slot busy", usart_pkg::A_FLAG, 32'h80, 32'h0);
		CTS_N <= 1'b0;
		i_usart_peer.grab(b0);
		chk("cts word", 32'h77, {24'h0, b0});
		wr(usart_pkg::A_CR3, 32'h0);
		// Reception, quiet line, overrun, break, blocking
		wr(usart_pkg::A_CR1, 32'hc05);
		i_usart_peer.send(9'h03c, 8, 1'b1);
		rc("rx avail", usart_pkg::A_FLAG, 32'h20, 32'h20);
		chk("rx irq", 32'h1, {31'h0, IRQ});
		rc("rx word", usart_pkg::A_DATA, 32'h1ff, 32'h3c);
		rc("rx avail clear", usart_pkg::A_FLAG, 32'h20, 32'h0);
		repeat (200) @(posedge MCLK);
		rc("line quiet", usart_pkg::A_FLAG, 32'h10, 32'h10);
		chk("quiet irq", 32'h1, {31'h0, IRQ});
		wr(usart_pkg::A_FLAG, 32'h10);
		i_usart_peer.send(9'h011, 8, 1'b1);
		i_usart_peer.send(9'h022, 8, 1'b1);
		rc("overrun flags", usart_pkg::A_FLAG, 32'h28, 32'h28);
		rc("overrun keeps first", usart_pkg::A_DATA, 32'h1ff, 32'h11);
		wr(usart_pkg::A_FLAG, 32'h18);
		i_usart_peer.send(9'h000, 8, 1'b0);
		rc("break flags", usart_pkg::A_FLAG, 32'h23, 32'h02);
		chk("break no irq", 32'h0, {31'h0, IRQ});
		rc("break word kept", usart_pkg::A_DATA, 32'h1ff, 32'h0);
		i_usart_peer.send(9'h05a, 8, 1'b1);
		rc("blocked rx", usart_pkg::A_FLAG, 32'h20, 32'h0);
		wr(usart_pkg::A_FLAG, 32'h1b);
		i_usart_peer.send(9'h05a, 8, 1'b1);
		rc("resumed rx", usart_pkg::A_DATA, 32'h1ff, 32'h5a);
		wr(usart_pkg::A_CR1, 32'h00d);
		i_usart_peer.send(9'h1a5, 9, 1'b1);
		rc("nine bit word", usart_pkg::A_DATA, 32'h1ff, 32'h1a5);
		// Synchronous master transmit
		wr(usart_pkg::A_BAUD, 32'h2);
		wr(usart_pkg::A_CR2, 32'h1);
		wr(usart_pkg::A_CR1, 32'h083);
		chk("clock pin driven", 32'h0, {31'h0, SCLK_OE_N});
		wr(usart_pkg::A_DATA, 32'ha5);
		n = 0;
		l = 0;
		per = 0;
		p = 1'b0;
		for (int c = 0; c < 300; c++) begin
			@(posedge MCLK);
			if (SCLK_OUT && !p) begin
				per = c - l;
				l = c;
				sb[n[4:0]] = TXD;
				n++;
			end
			p = SCLK_OUT;
		end
		chk("sync pulses", 32'h8, n);
		chk("sync period", 32'h8, per);
		chk("sync bits", 32'ha5, {24'h0, sb[7:0]});
		chk("sync rest", 32'h0, {31'h0, SCLK_OUT});
		wr(usart_pkg::A_CR2, 32'h3);
		wr(usart_pkg::A_CR1, 32'h081);
		repeat (4) @(posedge MCLK);
		chk("clock idle level", 32'h1, {31'h0, SCLK_OUT});
		results();
	end

	// Hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge MCLK);
		n_mismatch++;
		results();
	end
endmodule
`default_nettype wire
